/* logic/rgs_regs.svh */
// Purpose: Offsets, field positions and reset values of the remap status bank
// Assumes: Byte offsets as seen by the register port
// Notes: Definitions only
`ifndef RGS_REGS_SVH
`define RGS_REGS_SVH
`define RGS_CMD_OFF 12'h018
`define RGS_STS_OFF 12'h01C
`define RGS_STS_RST 32'h00000000
`define RGS_BIT_TRANS 31
`define RGS_BIT_ROOT 30
`define RGS_BIT_FLOG 29
`define RGS_BIT_AFLOG 28
`define RGS_BIT_WBF 27
`define RGS_BIT_QINV 26
`define RGS_BIT_IRQR 25
`define RGS_BIT_IRTP 24
`define RGS_BIT_CFI 23
`endif

/* logic/rgs_pkg.sv */
// Purpose: Types of the remap status bank
// Assumes: Nothing
// Notes: Handshake states for the pointer-load and flush operations
package rgs_pkg;
   typedef enum logic [2:0] {
      RGS_IDLE = 3'h1,
      RGS_BUSY = 3'h2,
      RGS_DONE = 3'h4
   } rgs_op_e;
endpackage

/* logic/rgs_op_track.sv */
// Purpose: Tracks one software-started operation and its status flag
// Assumes: start and done are single-cycle pulses on mclk
// Notes: BUSY_HIGH selects polarity of the flag while busy
`timescale 1ns/1ps
module rgs_op_track #(
   parameter bit BUSY_HIGH = 1'b0
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic done,
   output logic flag,
   output logic busy
);
   rgs_pkg::rgs_op_e state_ff;
   rgs_pkg::rgs_op_e nxt_state;
   logic flag_ff;
   logic nxt_flag;

   always_comb begin
      nxt_state = state_ff;
      nxt_flag = flag_ff;
      case (state_ff)
         rgs_pkg::RGS_IDLE, rgs_pkg::RGS_DONE: begin
            if (start) begin
               nxt_state = rgs_pkg::RGS_BUSY;
               nxt_flag = BUSY_HIGH;
            end
         end
         rgs_pkg::RGS_BUSY: begin
            if (start) begin
               nxt_flag = BUSY_HIGH;
            end else if (done) begin
               nxt_state = rgs_pkg::RGS_DONE;
               nxt_flag = ~BUSY_HIGH;
            end
         end
         default: begin
            nxt_state = rgs_pkg::RGS_IDLE;
            nxt_flag = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= rgs_pkg::RGS_IDLE;
         flag_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         flag_ff <= nxt_flag;
      end
   end

   assign flag = flag_ff;
   assign busy = (state_ff == rgs_pkg::RGS_BUSY);
endmodule

/* logic/rgs_status.sv */
// Purpose: Global status register of the DMA remapping unit
// Assumes: Command writes decoded here; engine reports completion as pulses
// Notes: All fields read-only; reads return registered data one cycle later
`timescale 1ns/1ps
`include "rgs_regs.svh"

module rgs_status #(
   parameter bit FLUSH_REQUIRED = 1'b1,
   parameter bit ADV_FLOG_SUPPORTED = 1'b1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [11:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   input wire logic translation_on,
   input wire logic adv_faultlog_on,
   input wire logic queued_inval_on,
   input wire logic irq_remap_on,
   input wire logic root_ptr_loaded,
   input wire logic faultlog_ptr_loaded,
   input wire logic irq_table_ptr_loaded,
   input wire logic wbuf_flush_done,
   output logic load_root_ptr_req,
   output logic load_faultlog_ptr_req,
   output logic load_irq_table_ptr_req,
   output logic wbuf_flush_req
);
   logic cmd_wr;
   logic sts_sel;
   logic cmd_sel;
   logic load_root_ptr_cmd;
   logic load_faultlog_ptr_cmd;
   logic wbuf_flush_cmd;
   logic load_irq_table_ptr_cmd;
   logic root_ptr_done_flag;
   logic faultlog_ptr_done_flag;
   logic wbuf_flush_pending_flag;
   logic irq_table_ptr_done_flag;
   logic compat_irq_pass_flag;
   logic [31:0] remap_global_status;
   logic [31:0] nxt_rdata;
   logic [31:0] rdata_ff;

   assign sts_sel = (reg_addr == `RGS_STS_OFF);
   assign cmd_sel = (reg_addr == `RGS_CMD_OFF);
   // Only the command register starts operations
   assign cmd_wr = reg_wr & cmd_sel;
   assign load_root_ptr_cmd = cmd_wr & reg_wdata[`RGS_BIT_ROOT];
   assign load_faultlog_ptr_cmd = cmd_wr & reg_wdata[`RGS_BIT_FLOG]
      & ADV_FLOG_SUPPORTED;
   // Writing 0 has no effect
   assign wbuf_flush_cmd = cmd_wr & reg_wdata[`RGS_BIT_WBF] & FLUSH_REQUIRED;
   assign load_irq_table_ptr_cmd = cmd_wr & reg_wdata[`RGS_BIT_IRTP];

   // Engine requests, completion pulses return on the *_loaded inputs and wbuf_flush_done
   assign load_root_ptr_req = load_root_ptr_cmd;
   assign load_faultlog_ptr_req = load_faultlog_ptr_cmd;
   assign load_irq_table_ptr_req = load_irq_table_ptr_cmd;
   assign wbuf_flush_req = wbuf_flush_cmd;

   // Clear on command, set on load completion
   rgs_op_track #(.BUSY_HIGH(1'b0)) u_root (
      .mclk(mclk),
      .rst_n(rst_n),
      .start(load_root_ptr_cmd),
      .done(root_ptr_loaded),
      .flag(root_ptr_done_flag),
      .busy()
   );

   // Fault-log pointer handshake
   rgs_op_track #(.BUSY_HIGH(1'b0)) u_flog (
      .mclk(mclk),
      .rst_n(rst_n),
      .start(load_faultlog_ptr_cmd),
      .done(faultlog_ptr_loaded),
      .flag(faultlog_ptr_done_flag),
      .busy()
   );

   // Flag high while flush runs
   rgs_op_track #(.BUSY_HIGH(1'b1)) u_wbf (
      .mclk(mclk),
      .rst_n(rst_n),
      .start(wbuf_flush_cmd),
      .done(wbuf_flush_done),
      .flag(wbuf_flush_pending_flag),
      .busy()
   );

   // Irq table pointer handshake
   rgs_op_track #(.BUSY_HIGH(1'b0)) u_irtp (
      .mclk(mclk),
      .rst_n(rst_n),
      .start(load_irq_table_ptr_cmd),
      .done(irq_table_ptr_loaded),
      .flag(irq_table_ptr_done_flag),
      .busy()
   );

   // Compat command is reserved zero, so blocked is reported
   assign compat_irq_pass_flag = 1'b0;

   always_comb begin
      remap_global_status = `RGS_STS_RST;
      remap_global_status[`RGS_BIT_TRANS] = translation_on;
      remap_global_status[`RGS_BIT_ROOT] = root_ptr_done_flag;
      remap_global_status[`RGS_BIT_FLOG] = faultlog_ptr_done_flag;
      remap_global_status[`RGS_BIT_AFLOG] = adv_faultlog_on
         & ADV_FLOG_SUPPORTED;
      remap_global_status[`RGS_BIT_WBF] = wbuf_flush_pending_flag;
      remap_global_status[`RGS_BIT_QINV] = queued_inval_on;
      remap_global_status[`RGS_BIT_IRQR] = irq_remap_on;
      remap_global_status[`RGS_BIT_IRTP] = irq_table_ptr_done_flag;
      remap_global_status[`RGS_BIT_CFI] = compat_irq_pass_flag;
   end

   // Command register reads as zero, unmapped reads as zero
   always_comb begin
      if (reg_rd && sts_sel) begin
         nxt_rdata = remap_global_status;
      end else begin
         nxt_rdata = 32'h00000000;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 32'h00000000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;
endmodule

/* tb/rgs_status_asserts.sv */
// Purpose: Port checks of the remap status bank
// Assumes: One clock mclk, async active-low rst_n
// Notes: Bound into rgs_status
`timescale 1ns/1ps
module rgs_status_asserts #(
   parameter bit FLUSH_REQUIRED = 1'b1,
   parameter bit ADV_FLOG_SUPPORTED = 1'b1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [11:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic translation_on,
   input wire logic adv_faultlog_on,
   input wire logic queued_inval_on,
   input wire logic irq_remap_on,
   input wire logic load_root_ptr_req,
   input wire logic load_faultlog_ptr_req,
   input wire logic load_irq_table_ptr_req,
   input wire logic wbuf_flush_req
);
   wire sts_rd = reg_rd && reg_addr == 12'h01C;
   wire cmd_wr = reg_wr && reg_addr == 12'h018;
   wire [2:0] lvl = {adv_faultlog_on, queued_inval_on, irq_remap_on};
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_cmd_rd(logic hit);
      cmd_wr && hit ##1 sts_rd;
   endsequence
   a_rd_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata not zero");
   a_resvd_zero: assert property (
      $past(reg_rd) |-> reg_rdata[23:0] == 24'h0)
      else $error("low bits not zero");
   a_trans_shown: assert property (
      sts_rd && $stable(translation_on)
      |=> reg_rdata[31] == $past(translation_on)) else $error("bit 31 wrong");
   a_levels_shown: assert property (
      sts_rd && $stable(lvl)
      |=> {reg_rdata[28], reg_rdata[26:25]}
      == ($past(lvl) & {ADV_FLOG_SUPPORTED, 2'b11}))
      else $error("level bits wrong");
   a_root_req: assert property (
      load_root_ptr_req == (cmd_wr && reg_wdata[30]))
      else $error("root req wrong");
   a_flog_req: assert property (
      load_faultlog_ptr_req
      == (cmd_wr && reg_wdata[29] && ADV_FLOG_SUPPORTED))
      else $error("flog req");
   a_irtp_req: assert property (
      load_irq_table_ptr_req == (cmd_wr && reg_wdata[24]))
      else $error("irq table req wrong");
   a_wbf_req: assert property (
      wbuf_flush_req == (cmd_wr && reg_wdata[27] && FLUSH_REQUIRED))
      else $error("flush req");
   a_root_clear: assert property (
      s_cmd_rd(reg_wdata[30]) |=> !reg_rdata[30])
      else $error("root flag not cleared");
   a_wbf_set: assert property (
      s_cmd_rd(reg_wdata[27] && FLUSH_REQUIRED) |=> reg_rdata[27])
      else $error("flush flag not set");
   a_cmd_rd_zero: assert property (
      reg_rd && reg_addr == 12'h018 |=> reg_rdata == 32'h0)
      else $error("command read not zero");
endmodule
bind rgs_status rgs_status_asserts #(.FLUSH_REQUIRED(FLUSH_REQUIRED),
   .ADV_FLOG_SUPPORTED(ADV_FLOG_SUPPORTED)) rgs_status_asserts_i (.mclk,
   .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
   .translation_on, .adv_faultlog_on, .queued_inval_on, .irq_remap_on,
   .load_root_ptr_req, .load_faultlog_ptr_req, .load_irq_table_ptr_req,
   .wbuf_flush_req);

/* tb/test_rgs_status.sv */
// Purpose: Directed test of the remap status bank
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Expected words written out per step
`timescale 1ns/1ps
module test_rgs_status;
   logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [3:0] lvl = 4'h0, done = 4'h0;
   wire [3:0] req;
   wire [31:0] lvl_word = {lvl[0], 2'b0, lvl[1], 1'b0, lvl[2], lvl[3],
      25'h0};
   int n_errors = 0, total_checks = 0;
   rgs_status rgs_status_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .translation_on(lvl[0]),
      .adv_faultlog_on(lvl[1]), .queued_inval_on(lvl[2]),
      .irq_remap_on(lvl[3]), .root_ptr_loaded(done[3]),
      .faultlog_ptr_loaded(done[2]), .irq_table_ptr_loaded(done[1]),
      .wbuf_flush_done(done[0]), .load_root_ptr_req(req[3]),
      .load_faultlog_ptr_req(req[2]), .load_irq_table_ptr_req(req[1]),
      .wbuf_flush_req(req[0]));
   task automatic cmp(logic [31:0] got, logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] r);
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = d;
      #1 cmp({28'h0, req}, {28'h0, r});
      @(posedge mclk);
      #1 reg_wr = 0;
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] e);
      reg_rd = 1;
      reg_addr = a;
      @(posedge mclk);
      #1 reg_rd = 0;
      cmp(reg_rdata, e);
      @(posedge mclk);
      #1;
   endtask
   task automatic pulse(int i);
      done[i] = 1;
      @(posedge mclk);
      #1 done[i] = 0;
   endtask
   task automatic wrap_up;
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial forever #2 mclk = ~mclk;
   initial begin
      #20000;
      n_errors++;
      wrap_up;
   end
   initial begin
      repeat (3) @(posedge mclk);
      #1 rst_n = 1;
      rd(12'h01C, 32'h0);
      rd(12'h018, 32'h0);
      rd(12'h020, 32'h0);
      for (int i = 0; i < 5; i++) begin
         lvl = 4'h1 << i;
         @(posedge mclk);
         #1 rd(12'h01C, lvl_word);
      end
      pulse(0);
      rd(12'h01C, 32'h0);
      wr(12'h018, 32'h61000000, 4'hE);
      rd(12'h01C, 32'h0);
      pulse(3);
      rd(12'h01C, 32'h40000000);
      pulse(2);
      rd(12'h01C, 32'h60000000);
      pulse(1);
      rd(12'h01C, 32'h61000000);
      wr(12'h01C, 32'hFFFFFFFF, 4'h0);
      rd(12'h01C, 32'h61000000);
      wr(12'h018, 32'h40000000, 4'h8);
      rd(12'h01C, 32'h21000000);
      wr(12'h018, 32'h08800000, 4'h1);
      rd(12'h01C, 32'h29000000);
      pulse(0);
      rd(12'h01C, 32'h21000000);
      wr(12'h018, 32'h0, 4'h0);
      rd(12'h01C, 32'h21000000);
      wr(12'h018, 32'h21000000, 4'h6);
      rd(12'h01C, 32'h00000000);
      pulse(3);
      rd(12'h01C, 32'h40000000);
      rst_n = 0;
      @(posedge mclk);
      #1 rst_n = 1;
      rd(12'h01C, 32'h00000000);
      wrap_up;
   end
endmodule
